// file: hw/bec_top.sv
// Purpose: boot mode control and lane steering configuration
// Assumes: straps are asynchronous pins, synchronised before use
// Notes: rom image is fed one rom-width piece at a time through a data port standing in for the bus
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module bec_top
  import bec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic endian_select_strap,
  input wire logic lane_correction_strap,
  input wire logic [1:0] boot_mode_strap,
  input wire logic [1:0] rom_width_strap,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cpu_stall,
  output logic cpu_int_pending,
  output logic [31:0] cpu_start_addr,
  output logic [31:0] external_data_bus,
  output logic byte_lane_enable_low,
  output logic byte_lane_enable_high
);
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic little_endian_select;
  logic big_endian_lane_fix;
  logic [1:0] boot_mode;
  logic [1:0] rom_width;
  logic captured;
  bec_state_t state;
  bec_state_t next_state;
  logic host_to_cpu_interrupt;
  logic next_int;
  logic int_pending;
  logic next_pending;
  logic [31:0] asm_word;
  logic [31:0] next_asm;
  logic [1:0] asm_cnt;
  logic [1:0] next_asm_cnt;
  logic [BEC_ADDR_W-1:0] copy_idx;
  logic [BEC_ADDR_W-1:0] next_copy_idx;
  logic copy_done;
  logic next_copy_done;
  logic [BEC_ADDR_W-1:0] mem_addr;
  logic [BEC_ADDR_W-1:0] next_mem_addr;
  logic [1:0] dev_width;
  logic [1:0] next_dev_width;
  logic [31:0] lane_in;
  logic [31:0] next_lane_in;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic rd_mem_pend;
  logic next_rd_mem_pend;
  logic wr_fire;
  logic mem_we;
  logic [BEC_ADDR_W-1:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic [BEC_ADDR_W-1:0] mem_raddr;
  logic [31:0] status_word;
  logic rom_strobe;
  logic word_ready;

  // merges a write strobe into an existing word
  function automatic logic [31:0] bec_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // strap synchroniser, two flops before use
  always_ff @(posedge aclk) begin
    sync1 <= {rom_width_strap, boot_mode_strap, lane_correction_strap, endian_select_strap};
    sync2 <= sync1;
  end

  // straps taken once after reset release and held to next reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      captured <= 1'b0;
      little_endian_select <= 1'b1;
      big_endian_lane_fix <= 1'b1;
      boot_mode <= 2'h0;
      rom_width <= 2'h2;
    end else if (!captured) begin
      captured <= 1'b1;
      little_endian_select <= sync2[0];
      big_endian_lane_fix <= sync2[1];
      boot_mode <= sync2[3:2];
      rom_width <= sync2[5:4];
    end
  end

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid && !rd_mem_pend;
  assign rom_strobe = wr_fire && aw_addr == BEC_OFS_ROM_DATA && state == BEC_S_COPY;
  assign word_ready = rom_strobe && (rom_width == 2'h2 || asm_cnt == (rom_width == 2'h0 ? 2'h3 : 2'h1));
  assign status_word = {24'h0, boot_mode, big_endian_lane_fix, little_endian_select, copy_done,
                        int_pending, host_to_cpu_interrupt, cpu_stall};

  // boot sequencing, interrupt bit and rom assembly
  always_comb begin
    next_state = state;
    next_int = host_to_cpu_interrupt;
    next_pending = int_pending;
    next_asm = asm_word;
    next_asm_cnt = asm_cnt;
    next_copy_idx = copy_idx;
    next_copy_done = copy_done;
    mem_we = 1'b0;
    mem_waddr = mem_addr;
    mem_wdata = bec_merge(32'h0, w_data, w_strb);
    case (state)
      BEC_S_RESET: begin
        if (captured) begin
          next_state = (bec_mode_t'(boot_mode) == BEC_BOOT_ROM) ? BEC_S_COPY : BEC_S_STALL;
        end
      end
      BEC_S_STALL: begin
        if (wr_fire && aw_addr == BEC_OFS_CTRL && w_strb[0] && w_data[BEC_CTRL_INT_BIT]) begin
          next_int = 1'b1;
          // stall exit for any boot mode other than rom, no pending latched
          if (bec_mode_t'(boot_mode) != BEC_BOOT_ROM) begin
            next_state = BEC_S_RUN;
          end
        end
      end
      BEC_S_COPY: begin
        if (rom_strobe) begin
          // pieces arrive in system byte order, low piece first
          case (rom_width)
            2'h0: next_asm = {w_data[7:0], asm_word[31:8]};
            2'h1: next_asm = {w_data[15:0], asm_word[31:16]};
            default: next_asm = w_data;
          endcase
          next_asm_cnt = word_ready ? 2'h0 : asm_cnt + 2'h1;
        end
        if (word_ready) begin
          mem_we = 1'b1;
          mem_waddr = copy_idx;
          mem_wdata = next_asm;
          next_copy_idx = copy_idx + 1'b1;
          if (copy_idx == BEC_ADDR_W'(BEC_ROM_BYTES / 4 - 1)) begin
            next_copy_done = 1'b1;
            next_state = BEC_S_RUN;
          end
        end
      end
      BEC_S_RUN: begin
        if (wr_fire && aw_addr == BEC_OFS_CTRL && w_strb[0]) begin
          if (w_data[BEC_CTRL_CPU_CLR_BIT]) begin
            next_int = 1'b0;
          end else if (w_data[BEC_CTRL_INT_BIT] && !host_to_cpu_interrupt) begin
            next_int = 1'b1;
            next_pending = 1'b1;
          end
        end
        if (next_int == 1'b0) begin
          next_pending = 1'b0;
        end
      end
      default: next_state = BEC_S_RESET;
    endcase
    if (state == BEC_S_STALL && bec_mode_t'(boot_mode) != BEC_BOOT_ROM
        && wr_fire && aw_addr == BEC_OFS_MEM_DATA) begin
      mem_we = 1'b1;
      mem_waddr = mem_addr;
      mem_wdata = bec_merge(32'h0, w_data, w_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= BEC_S_RESET;
      host_to_cpu_interrupt <= 1'b0;
      int_pending <= 1'b0;
      asm_word <= 32'h0000_0000;
      asm_cnt <= 2'h0;
      copy_idx <= '0;
      copy_done <= 1'b0;
    end else begin
      state <= next_state;
      host_to_cpu_interrupt <= next_int;
      int_pending <= next_pending;
      asm_word <= next_asm;
      asm_cnt <= next_asm_cnt;
      copy_idx <= next_copy_idx;
      copy_done <= next_copy_done;
    end
  end

  assign cpu_stall = state != BEC_S_RUN;
  assign cpu_int_pending = int_pending;
  assign cpu_start_addr = BEC_ROM_BASE;

  // register bus slave
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rd_mem_pend = 1'b0;
    next_mem_addr = mem_addr;
    next_dev_width = dev_width;
    next_lane_in = lane_in;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = BEC_RESP_OKAY;
      case (aw_addr)
        BEC_OFS_CTRL: begin
          // width field sits in the lowest byte, so only that strobe moves it
          if (w_strb[0]) begin
            next_dev_width = w_data[BEC_CTRL_WIDTH_LSB +: 2];
          end
        end
        BEC_OFS_MEM_ADDR: next_mem_addr = w_data[BEC_ADDR_W+1:2];
        BEC_OFS_LANE_IN: next_lane_in = bec_merge(lane_in, w_data, w_strb);
        BEC_OFS_MEM_DATA, BEC_OFS_ROM_DATA, BEC_OFS_ROM_ADDR: next_bresp = BEC_RESP_OKAY;
        default: next_bresp = BEC_RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rd_mem_pend) begin
      next_rvalid = 1'b1;
      next_rdata = mem_rdata;
      next_rresp = BEC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      next_rresp = BEC_RESP_OKAY;
      next_rvalid = 1'b1;
      case (s_axi_araddr[7:0])
        BEC_OFS_CTRL: next_rdata = {26'h0, dev_width, 3'h0, host_to_cpu_interrupt};
        BEC_OFS_STATUS: next_rdata = status_word;
        BEC_OFS_ROM_ADDR: next_rdata = {22'h0, copy_idx, 2'h0};
        BEC_OFS_MEM_ADDR: next_rdata = {22'h0, mem_addr, 2'h0};
        BEC_OFS_LANE_IN: next_rdata = lane_in;
        BEC_OFS_LANE_OUT: next_rdata = external_data_bus;
        BEC_OFS_MEM_DATA: begin
          next_rvalid = 1'b0;
          next_rd_mem_pend = 1'b1;
        end
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = BEC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BEC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= BEC_RESP_OKAY;
      rd_mem_pend <= 1'b0;
      mem_addr <= '0;
      dev_width <= 2'h2;
      lane_in <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      rd_mem_pend <= next_rd_mem_pend;
      mem_addr <= next_mem_addr;
      dev_width <= next_dev_width;
      lane_in <= next_lane_in;
    end
  end

  assign mem_raddr = mem_addr;

  bec_mem u_mem (
    .aclk(aclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  bec_lane u_lane (
    .aclk(aclk),
    .aresetn(aresetn),
    .little_endian_select(little_endian_select),
    .big_endian_lane_fix(big_endian_lane_fix),
    .dev_width(dev_width),
    .data_in(lane_in),
    .external_data_bus(external_data_bus),
    .byte_lane_enable_low(byte_lane_enable_low),
    .byte_lane_enable_high(byte_lane_enable_high)
  );

  AST_RESET_STALL: assert property (@(posedge aclk) !aresetn |=> cpu_stall && !host_to_cpu_interrupt)
    else $error("reset must stall cpu");
  AST_STRAP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    captured && $past(captured) |-> $stable(boot_mode) && $stable(little_endian_select))
    else $error("straps changed after capture");
  AST_NO_PEND_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BEC_S_STALL |=> !int_pending)
    else $error("interrupt latched during stall");
  AST_ROM_NO_INT_REL: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == BEC_S_COPY && !word_ready) |=> cpu_stall)
    else $error("rom boot released without copy");
  AST_HOST_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == BEC_S_STALL && wr_fire && aw_addr == BEC_OFS_CTRL && w_strb[0] && w_data[0])
      |=> !cpu_stall && host_to_cpu_interrupt)
    else $error("host interrupt did not release stall");
  AST_COPY_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(copy_done) |-> !cpu_stall && copy_idx == '0)
    else $error("copy finish mismatch");
  AST_RUN_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
    !cpu_stall |=> !cpu_stall)
    else $error("stall returned without reset");
  AST_INT_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == BEC_S_RUN && host_to_cpu_interrupt && !int_pending) |=> !int_pending)
    else $error("interrupt accepted before clear");
endmodule

// file: shared/bec_pkg.sv
// Purpose: constants and types for the boot and lane configuration block
// Assumes: 32-bit data words, AXI4-Lite register access
// Notes: offsets are byte addresses
package bec_pkg;
  localparam logic [7:0] BEC_OFS_CTRL = 8'h00;
  localparam logic [7:0] BEC_OFS_STATUS = 8'h04;
  localparam logic [7:0] BEC_OFS_ROM_ADDR = 8'h08;
  localparam logic [7:0] BEC_OFS_ROM_DATA = 8'h0C;
  localparam logic [7:0] BEC_OFS_MEM_ADDR = 8'h10;
  localparam logic [7:0] BEC_OFS_MEM_DATA = 8'h14;
  localparam logic [7:0] BEC_OFS_LANE_IN = 8'h18;
  localparam logic [7:0] BEC_OFS_LANE_OUT = 8'h1C;
  localparam int BEC_CTRL_INT_BIT = 0;
  localparam int BEC_CTRL_CPU_CLR_BIT = 1;
  localparam int BEC_CTRL_WIDTH_LSB = 4;
  localparam int BEC_ST_STALL_BIT = 0;
  localparam int BEC_ST_INT_BIT = 1;
  localparam int BEC_ST_PEND_BIT = 2;
  localparam int BEC_ST_DONE_BIT = 3;
  localparam int BEC_ST_LE_BIT = 4;
  localparam int BEC_ST_FIX_BIT = 5;
  localparam int BEC_ST_MODE_LSB = 6;
  localparam int BEC_MEM_WORDS = 256;
  localparam int BEC_ADDR_W = 8;
  localparam logic [31:0] BEC_ROM_BYTES = 32'h0000_0400;
  localparam logic [31:0] BEC_ROM_BASE = 32'h0000_0000;
  localparam logic [1:0] BEC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BEC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {BEC_BOOT_HOST, BEC_BOOT_EMU, BEC_BOOT_ROM} bec_mode_t;
  typedef enum logic [1:0] {BEC_W8, BEC_W16, BEC_W32} bec_width_t;
  typedef enum {BEC_S_RESET, BEC_S_STALL, BEC_S_COPY, BEC_S_RUN} bec_state_t;
endpackage

// file: hw/bec_mem.sv
// Purpose: boot memory written by host or rom copy, read back registered
// Assumes: one write port, one read port
// Notes: contents are not cleared by reset
`timescale 1ns/1ns
module bec_mem
  import bec_pkg::*;
(
  input wire logic aclk,
  input wire logic we,
  input wire logic [BEC_ADDR_W-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [BEC_ADDR_W-1:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [BEC_MEM_WORDS];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: hw/bec_lane.sv
// Purpose: steers narrow device data to its byte lanes
// Assumes: straps already captured
// Notes: registered output
`timescale 1ns/1ns
module bec_lane
  import bec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic little_endian_select,
  input wire logic big_endian_lane_fix,
  input wire logic [1:0] dev_width,
  input wire logic [31:0] data_in,
  output logic [31:0] external_data_bus,
  output logic byte_lane_enable_low,
  output logic byte_lane_enable_high
);
  logic [31:0] next_bus;
  logic next_low;
  logic next_high;
  logic low_side;

  always_comb begin
    // fix strap high: big endian uses top lanes; low: always bottom lanes
    low_side = little_endian_select || !big_endian_lane_fix;
    next_bus = 32'h0000_0000;
    next_low = 1'b0;
    next_high = 1'b0;
    case (bec_width_t'(dev_width))
      BEC_W32: begin
        next_bus = data_in;
        next_low = 1'b1;
        next_high = 1'b1;
      end
      BEC_W16: begin
        if (low_side) begin
          next_bus = {16'h0000, data_in[15:0]};
          next_low = 1'b1;
        end else begin
          next_bus = {data_in[15:0], 16'h0000};
          next_high = 1'b1;
        end
      end
      BEC_W8: begin
        if (low_side) begin
          next_bus = {24'h000000, data_in[7:0]};
          next_low = 1'b1;
        end else begin
          next_bus = {data_in[7:0], 24'h000000};
          next_high = 1'b1;
        end
      end
      default: begin
        next_bus = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_data_bus <= 32'h0000_0000;
      byte_lane_enable_low <= 1'b0;
      byte_lane_enable_high <= 1'b0;
    end else begin
      external_data_bus <= next_bus;
      byte_lane_enable_low <= next_low;
      byte_lane_enable_high <= next_high;
    end
  end

  AST_LANE_FIX_OFF_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    (!big_endian_lane_fix && bec_width_t'(dev_width) != BEC_W32) |=> byte_lane_enable_low && !byte_lane_enable_high)
    else $error("lane fix off must use low lanes");
  AST_LANE_BIG_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
    (big_endian_lane_fix && !little_endian_select && bec_width_t'(dev_width) == BEC_W8)
      |=> external_data_bus[31:24] == $past(data_in[7:0]) && external_data_bus[23:0] == 24'h000000)
    else $error("big endian byte not on top lane");
  AST_LANE_WIDE: assert property (@(posedge aclk) disable iff (!aresetn)
    (bec_width_t'(dev_width) == BEC_W32) |=> external_data_bus == $past(data_in))
    else $error("32-bit device must use all lanes");
endmodule

// file: bench/bec_rom_model.sv
// Purpose: boot rom image standing on the far side of the copy path
// Assumes: one 32-bit word per index, as a 32-bit rom presents it
// Notes: pattern lets every word be recomputed by the bench
`timescale 1ns/1ns
module bec_rom_model
  import bec_pkg::*;
(
  input wire logic [7:0] word_idx,
  output logic [31:0] rom_word
);
  // image held already in the byte order the system runs in
  always_comb begin
    rom_word = {8'hC3, word_idx, 8'h5A, ~word_idx};
  end
endmodule

// file: bench/tb_bec_top.sv
// Purpose: register-level bench for bec_top
// Assumes: straps only matter around reset
// Notes: rom words come from bec_rom_model
`timescale 1ns/1ns
module tb_bec_top
  import bec_pkg::*;
;
  logic aclk, aresetn, endian_select_strap, lane_correction_strap;
  logic [1:0] boot_mode_strap, rom_width_strap, s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, cpu_start_addr, external_data_bus;
  logic [31:0] rom_word, rd, ex, mk;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_stall, cpu_int_pending;
  logic byte_lane_enable_low, byte_lane_enable_high, lo, hi;
  logic [7:0] rom_idx;
  int err_count, checks;

  bec_top bec_top_inst (.aclk, .aresetn, .endian_select_strap, .lane_correction_strap, .boot_mode_strap,
    .rom_width_strap, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cpu_stall, .cpu_int_pending, .cpu_start_addr, .external_data_bus, .byte_lane_enable_low,
    .byte_lane_enable_high);
  bec_rom_model bec_rom_model_inst (.word_idx(rom_idx), .rom_word(rom_word));

  task automatic close_out;
    begin
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checks++;
      if (g !== e) begin
        err_count++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task automatic tick(input int n);
    begin
      if (n > 100) begin
        err_count++;
        close_out;
      end
    end
  endtask

  // ready sampled mid-cycle; it only moves after rising edges
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ah, wh, bh;
    begin
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      bh = 1'b0;
      n = 0;
      while (!bh) begin
        @(negedge aclk);
        ah = s_axi_awvalid && s_axi_awready;
        wh = s_axi_wvalid && s_axi_wready;
        bh = s_axi_bvalid;
        rs = s_axi_bresp;
        @(posedge aclk);
        if (ah) s_axi_awvalid <= 1'b0;
        if (wh) s_axi_wvalid <= 1'b0;
        n++;
        tick(n);
      end
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    int n;
    logic ah, rh;
    begin
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      rh = 1'b0;
      n = 0;
      while (!rh) begin
        @(negedge aclk);
        ah = s_axi_arvalid && s_axi_arready;
        rh = s_axi_rvalid;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge aclk);
        if (ah) s_axi_arvalid <= 1'b0;
        n++;
        tick(n);
      end
      chk(nm, e, rd & m);
    end
  endtask

  task automatic pins(input logic xs, input logic xp);
    begin
      @(negedge aclk);
      chk("cpu_stall", {31'h0, xs}, {31'h0, cpu_stall});
      chk("cpu_int_pending", {31'h0, xp}, {31'h0, cpu_int_pending});
      chk("cpu_start_addr", 32'h0, cpu_start_addr);
      @(posedge aclk);
    end
  endtask

  task automatic rst(input logic e, input logic f, input logic [1:0] m);
    begin
      endian_select_strap <= e;
      lane_correction_strap <= f;
      boot_mode_strap <= m;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk("stall in reset", 32'h1, {31'h0, cpu_stall});
      chk("bvalid in reset", 32'h0, {31'h0, s_axi_bvalid});
      @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    {endian_select_strap, lane_correction_strap, boot_mode_strap, rom_width_strap} = 6'h32;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    // response readies stay high so back-to-back calls never toggle them
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
    s_axi_wstrb = 4'hF;
    rom_idx = 8'h0;
    err_count = 0;
    checks = 0;
    @(posedge aclk);
    for (int e = 0; e < 2; e++) begin
      for (int f = 0; f < 2; f++) begin
        rst(e[0], f[0], 2'h0);
        ex = {24'h0, 2'h0, f[0], e[0], 4'h1};
        rdchk(BEC_OFS_STATUS, ex, 32'hFF, "status straps");
        // straps flipped after release must not reach the lanes
        endian_select_strap <= ~e[0];
        lane_correction_strap <= ~f[0];
        for (int w = 0; w < 3; w++) begin
          axw(BEC_OFS_CTRL, 32'(w) << 4);
          axw(BEC_OFS_LANE_IN, 32'h44332211);
          mk = (w == 0) ? 32'h000000FF : (w == 1) ? 32'h0000FFFF : 32'hFFFFFFFF;
          {hi, lo} = (w == 2) ? 2'h3 : 2'h1;
          if (w < 2 && f == 1 && e == 0) begin
            mk = mk << ((w == 0) ? 24 : 16);
            {hi, lo} = 2'h2;
          end
          ex = (w == 2) ? 32'h44332211 : (w == 0) ? 32'h11111111 & mk : 32'h22112211 & mk;
          rdchk(BEC_OFS_LANE_OUT, ex, 32'hFFFFFFFF, "lane out");
          @(negedge aclk);
          chk("lane bus", ex, external_data_bus);
          chk("lane enables", {30'h0, hi, lo}, {30'h0, byte_lane_enable_high, byte_lane_enable_low});
          @(posedge aclk);
        end
        rdchk(BEC_OFS_STATUS, {24'h0, 2'h0, f[0], e[0], 4'h0}, 32'hF0, "status held");
      end
    end
    for (int m = 0; m < 2; m++) begin
      rst(1'b1, 1'b1, m[1:0]);
      pins(1'b1, 1'b0);
      if (m == 1) begin
        chk("emu start addr", 32'h0, cpu_start_addr);
      end
      if (m == 0) begin
        axw(BEC_OFS_MEM_ADDR, 32'h10);
        axw(BEC_OFS_MEM_DATA, 32'hCAFE0123);
        chk("mem wresp", {30'h0, BEC_RESP_OKAY}, {30'h0, rs});
        rdchk(BEC_OFS_MEM_DATA, 32'hCAFE0123, 32'hFFFFFFFF, "mem readback");
      end
      // host or emulator sets the interrupt bit to end the stall
      axw(BEC_OFS_CTRL, 32'h21);
      pins(1'b0, 1'b0);
      rdchk(BEC_OFS_STATUS, 32'h2, 32'h7, "released status");
      axw(BEC_OFS_CTRL, 32'h21);
      rdchk(BEC_OFS_STATUS, 32'h2, 32'h7, "set while bit set");
      axw(BEC_OFS_CTRL, 32'h22);
      axw(BEC_OFS_CTRL, 32'h21);
      rdchk(BEC_OFS_STATUS, 32'h6, 32'h7, "pending after clear");
      pins(1'b0, 1'b1);
    end
    // 8-bit rom sends each word as four bytes, low byte first; 32-bit rom as one word
    for (int r = 0; r < 3; r += 2) begin
      rom_width_strap <= r[1:0];
      rst(1'b1, 1'b1, 2'h2);
      axw(BEC_OFS_CTRL, 32'h21);
      pins(1'b1, 1'b0);
      for (int i = 0; i < 256; i++) begin
        rom_idx <= i[7:0];
        @(posedge aclk);
        for (int p = 0; p < ((r == 0) ? 4 : 1); p++) begin
          axw(BEC_OFS_ROM_DATA, rom_word >> (8 * p));
        end
      end
      rdchk(BEC_OFS_STATUS, 32'h8, 32'h9, "copy done");
      pins(1'b0, 1'b0);
      for (int i = 0; i < 256; i += 255) begin
        axw(BEC_OFS_MEM_ADDR, 32'(i) << 2);
        rdchk(BEC_OFS_MEM_DATA, {8'hC3, i[7:0], 8'h5A, ~i[7:0]}, 32'hFFFFFFFF, "copied word");
      end
    end
    rdchk(8'h40, 32'h0, 32'hFFFFFFFF, "unmapped data");
    chk("unmapped resp", {30'h0, BEC_RESP_SLVERR}, {30'h0, rs});
    axw(8'h40, 32'h0);
    chk("unmapped wresp", {30'h0, BEC_RESP_SLVERR}, {30'h0, rs});
    close_out;
  end
endmodule
